// >>> tb/fwsc_array_model.sv
`timescale 1ns/1ps
`default_nettype none
// Flash array stand-in: may finish a timed write early
module fwsc_array_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Command side
   input wire logic start_i,
   input wire logic [7:0] dly_i,
   output logic done_o
);
   logic [7:0] cnt_r; // Cycles left, zero when idle
   // Zero delay leaves the timing to the block's own timer
   always_ff @(posedge clk_i) begin
      done_o <= 1'b0;
      if (rst_i) begin
         cnt_r <= 8'h00;
      end else if (start_i && dly_i != 8'h00) begin
         cnt_r <= dly_i;
      end else if (cnt_r != 8'h00) begin
         cnt_r <= cnt_r - 8'h01;
         done_o <= (cnt_r == 8'h01);
      end
   end
endmodule
`default_nettype wire

// >>> tb/fwsc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module fwsc_top_test;
   import fwsc_pkg::*;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   localparam int WCYC = 20; // Short timed write keeps the run brief
   localparam int FRZ = 10; // Cycles the enable is held low mid-write
   logic ce = 1'b1; // Clock enable, dropped to freeze the block
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] dat = 32'h0;
   logic [31:0] rdat;
   logic [31:0] rd; // Last read data
   logic ack;
   logic stall;
   logic done;
   logic [7:0] dly = 8'h00; // Early finish delay, zero is off
   fwsc_cmd_t cmd;
   int errors = 0;
   int n_checks = 0;
   int cnt = 0;
   int t_w, t_ack, t_st;
   int n_st = 0;
   int n_stall = 0;
   logic st_erase;
   logic [13:0] st_addr;
   logic st_latch;
   always #5 clk_i = ~clk_i;
   fwsc_top #(.WRITE_CYC(WCYC), .CNT_W(18)) u_fwsc_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .stall_o(stall), .cmd_o(cmd), .array_done_i(done));
   fwsc_array_model u_fwsc_array_model (.clk_i(clk_i), .rst_i(rst_i), .start_i(cmd.start),
      .dly_i(dly), .done_o(done));
   // Monitor: both sides read the pre-edge cycle number
   always @(posedge clk_i) begin
      cnt <= cnt + 1;
      if (cmd.start === 1'b1) begin
         n_st++;
         t_st = cnt;
         st_erase = cmd.erase;
         st_addr = cmd.addr;
         st_latch = cmd.latch;
      end
      if (stall === 1'b1) n_stall++;
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("FAIL at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chkn(input int got, input int exp);
      chk(32'(got), 32'(exp));
   endtask
   task automatic close_out;
      $display("Counts: %0d checks, %0d mismatches", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Classic single cycle, held until ack is sampled
   task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 50);
      if (k >= 50) begin
         errors++;
         close_out();
      end
      rd = rdat;
      t_w = cnt;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   // Counters cleared away from the monitor's edge
   task automatic clr;
      @(negedge clk_i);
      n_st = 0;
      n_stall = 0;
   endtask
   // Unlock pair, then the trigger write; bus stays quiet after it
   task automatic fire(input logic [31:0] c);
      wb(FWSC_UNLK_ADR, 1'b1, {24'h0, FWSC_KEY1});
      wb(FWSC_UNLK_ADR, 1'b1, {24'h0, FWSC_KEY2});
      wb(FWSC_CTRL_ADR, 1'b1, c);
      t_ack = t_w;
      // Two idle slots stand for the no-ops
      repeat (2) @(posedge clk_i);
   endtask
   // Poll until hardware drops the trigger, bounded
   task automatic wait_done;
      int k;
      k = 0;
      do begin
         wb(FWSC_CTRL_ADR, 1'b0, 32'h0);
         k++;
      end while (rd[FWSC_B_TRIG] !== 1'b0 && k < 100);
      if (k >= 100) begin
         errors++;
         close_out();
      end
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      // Reset values, address widths, unmapped place
      wb(FWSC_CTRL_ADR, 1'b0, 32'h0);
      chk(rd, 32'h0);
      wb(4'h2, 1'b0, 32'h0);
      chk(rd, 32'h0);
      wb(FWSC_ADRH_ADR, 1'b1, 32'hFF);
      wb(FWSC_ADRH_ADR, 1'b0, 32'h0);
      chk(rd, 32'h3F);
      wb(FWSC_ADRL_ADR, 1'b1, 32'h1A5);
      wb(FWSC_ADRL_ADR, 1'b0, 32'h0);
      chk(rd, 32'hA5);
      $display("Test reset and address done");
      // Program with the block's own timer
      clr();
      fire(32'h06);
      wait_done();
      chkn(t_st - t_ack, 2);
      chkn(n_st, 1);
      // Stall also spans the timer's expiry flop and the release cycle
      chkn(n_stall, WCYC + 2);
      chk({17'h0, st_erase, st_addr}, 32'h3FA5);
      chk(rd, 32'h04);
      $display("Test program done");
      // Erase, array answers early
      clr();
      dly <= 8'h05;
      fire(32'h16);
      wait_done();
      dly <= 8'h00;
      chk({31'h0, st_erase}, 32'h1);
      chkn(n_stall > 0 && n_stall < WCYC, 1);
      $display("Test erase done");
      // Latch-only load never stalls
      clr();
      fire(32'h26);
      wait_done();
      chkn(n_st, 1);
      chkn(n_stall, 0);
      chk({31'h0, st_latch}, 32'h1);
      $display("Test latch done");
      // Low enable freezes the stall; it stretches by the frozen cycles
      clr();
      fire(32'h06);
      repeat (5) @(posedge clk_i);
      ce <= 1'b0;
      repeat (FRZ) @(posedge clk_i);
      ce <= 1'b1;
      wait_done();
      chkn(n_stall, WCYC + 2 + FRZ);
      chk(rd, 32'h04);
      $display("Test freeze done");
      // Trigger without unlock is refused
      clr();
      wb(FWSC_CTRL_ADR, 1'b1, 32'h06);
      wb(FWSC_CTRL_ADR, 1'b0, 32'h0);
      chk({31'h0, rd[FWSC_B_ERR]}, 32'h1);
      chkn(n_st + n_stall, 0);
      wb(FWSC_CTRL_ADR, 1'b1, 32'h0);
      wb(FWSC_CTRL_ADR, 1'b0, 32'h0);
      chk(rd, 32'h0);
      $display("Test refusal done");
      close_out();
   end
endmodule
`default_nettype wire

// >>> verilog/fwsc_pkg.sv
// What this block does
// - Two setup cycles after trigger before programming
// - Core halts only for final word write or row erase
// - Clocks and peripherals keep running while stalled
// - Latch-only load never stalls or programs array
// - Resume at third instruction after trigger
// - Erase-select makes trigger erase the row
// - High register upper 6 bits, low 8
`default_nettype none
package fwsc_pkg;
   // ------------------------------------------------------------
   // Register map (word aligned byte addresses)
   // ------------------------------------------------------------
   localparam logic [3:0] FWSC_CTRL_ADR = 4'h0; // Control: trigger, erase, latch, enable
   localparam logic [3:0] FWSC_UNLK_ADR = 4'h4; // Unlock key register
   localparam logic [3:0] FWSC_ADRH_ADR = 4'h8; // Address high
   localparam logic [3:0] FWSC_ADRL_ADR = 4'hC; // Address low
   // ------------------------------------------------------------
   // Control field positions
   // ------------------------------------------------------------
   localparam int FWSC_B_TRIG = 1; // Write trigger, set only
   localparam int FWSC_B_WEN = 2; // Write enable
   localparam int FWSC_B_ERR = 3; // Write aborted flag
   localparam int FWSC_B_ERASE = 4; // Erase select
   localparam int FWSC_B_LATCH = 5; // Latch-only load
   // ------------------------------------------------------------
   // Keys, widths and timing
   // ------------------------------------------------------------
   localparam logic [7:0] FWSC_KEY1 = 8'h55; // First unlock key
   localparam logic [7:0] FWSC_KEY2 = 8'hAA; // Second unlock key
   localparam int FWSC_AH_W = 6; // High address bits
   localparam int FWSC_AL_W = 8; // Low address bits
   localparam logic [1:0] FWSC_SETUP_CYC = 2'h2; // Preparation cycles
   localparam int FWSC_CLK_MHZ = 100; // System clock rate
   localparam int FWSC_WRITE_US = 2000; // Timed write, 2 ms
   localparam int FWSC_WRITE_CYC = FWSC_WRITE_US * FWSC_CLK_MHZ; // Cycles for timed write
   // ------------------------------------------------------------
   // Sequencer states, one-hot
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      FWSC_IDLE = 4'h1, // Waiting for trigger
      FWSC_SETUP = 4'h2, // Preparing operation
      FWSC_BUSY = 4'h4, // Array timed write
      FWSC_DONE = 4'h8 // Release stall
   } fwsc_state_t;
   // Command handed to the flash array
   typedef struct packed {
      logic start; // One-cycle start pulse
      logic erase; // Row erase instead of program
      logic latch; // Latch load only
      logic [FWSC_AH_W+FWSC_AL_W-1:0] addr; // Full 14-bit address
   } fwsc_cmd_t;
endpackage
`default_nettype wire

// >>> verilog/fwsc_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Down counter for the self-timed write
module fwsc_timer
   import fwsc_pkg::*;
#(
   parameter int CNT_W = 18
) (
   // Clock and control
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Load and status
   input wire logic load_i,
   input wire logic [CNT_W-1:0] count_i,
   output logic expired_o
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [CNT_W-1:0] cnt; // Remaining cycles
      logic exp; // Expiry pulse
   } fwsc_tmr_t;
   fwsc_tmr_t s_r;
   fwsc_tmr_t s_nxt;
   // Next state
   always_comb begin
      s_nxt = s_r;
      s_nxt.exp = 1'b0;
      if (load_i) begin
         s_nxt.cnt = count_i;
      end else if (s_r.cnt != '0) begin
         s_nxt.cnt = s_r.cnt - 1'b1;
         s_nxt.exp = (s_r.cnt == {{(CNT_W-1){1'b0}}, 1'b1});
      end
   end
   // Register, frozen when clock enable low
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else if (ce_i) begin
         s_r <= s_nxt;
      end
   end
   assign expired_o = s_r.exp;
endmodule
`default_nettype wire

// >>> verilog/fwsc_top.sv
// The register addresses and register access over Wishbone were decided locally.
`timescale 1ns/1ps
`default_nettype none
module fwsc_top
   import fwsc_pkg::*;
#(
   parameter int WRITE_CYC = FWSC_WRITE_CYC, // Timed write length in cycles
   parameter int CNT_W = 18 // Timer width, must hold WRITE_CYC
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Core stall, array command
   output logic stall_o,
   output fwsc_cmd_t cmd_o,
   input wire logic array_done_i
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      fwsc_state_t st; // Sequencer state
      logic [1:0] setup; // Setup cycles left
      logic [1:0] key; // Unlock progress
      logic trig; // Write trigger
      logic wen; // Write enable
      logic err; // Aborted write
      logic erase; // Erase select
      logic latch; // Latch-only load
      logic [FWSC_AH_W-1:0] ah; // Address high
      logic [FWSC_AL_W-1:0] al; // Address low
      logic stall; // Core halt
      fwsc_cmd_t cmd; // Array command
      logic ack; // Bus acknowledge
      logic [31:0] dat; // Bus read data
   } fwsc_regs_t;
   fwsc_regs_t s_r;
   fwsc_regs_t s_nxt;
   logic tmr_exp; // Timed write elapsed
   logic tmr_load; // Start timed write
   logic acc; // New bus access
   logic wr_lo; // Write to byte lane 0
   // Access decode, ack drops after one cycle
   assign acc = wb_cyc_i && wb_stb_i && !s_r.ack;
   assign wr_lo = acc && wb_we_i && wb_sel_i[0];
   assign tmr_load = (s_r.st == FWSC_SETUP) && (s_r.setup == 2'h1) && !s_r.latch;
   // Control byte as software sees it
   function automatic logic [7:0] ctrl_byte(input fwsc_regs_t s);
      logic [7:0] b;
      b = 8'h00;
      b[FWSC_B_TRIG] = s.trig;
      b[FWSC_B_WEN] = s.wen;
      b[FWSC_B_ERR] = s.err;
      b[FWSC_B_ERASE] = s.erase;
      b[FWSC_B_LATCH] = s.latch;
      return b;
   endfunction
   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.ack = acc;
      s_nxt.cmd.start = 1'b0;
      s_nxt.cmd.addr = {s_r.ah, s_r.al};
      // Register reads
      if (acc && !wb_we_i) begin
         if (wb_adr_i == FWSC_CTRL_ADR) begin
            s_nxt.dat = {24'h000000, ctrl_byte(s_r)};
         end else if (wb_adr_i == FWSC_ADRH_ADR) begin
            s_nxt.dat = {26'h0000000, s_r.ah};
         end else if (wb_adr_i == FWSC_ADRL_ADR) begin
            s_nxt.dat = {24'h000000, s_r.al};
         end else begin
            s_nxt.dat = 32'h00000000; // Unlock and unmapped read zero
         end
      end
      // Register writes; config frozen while operation runs
      if (wr_lo) begin
         if (wb_adr_i == FWSC_UNLK_ADR) begin
            if (wb_dat_i[7:0] == FWSC_KEY1) begin
               s_nxt.key = 2'h1;
            end else if (wb_dat_i[7:0] == FWSC_KEY2 && s_r.key == 2'h1) begin
               s_nxt.key = 2'h2;
            end else begin
               s_nxt.key = 2'h0;
            end
         end else if (wb_adr_i == FWSC_CTRL_ADR) begin
            s_nxt.key = 2'h0; // Any other write breaks the sequence
            if (s_r.st == FWSC_IDLE) begin
               s_nxt.wen = wb_dat_i[FWSC_B_WEN];
               s_nxt.erase = wb_dat_i[FWSC_B_ERASE];
               s_nxt.latch = wb_dat_i[FWSC_B_LATCH];
               s_nxt.err = s_r.err & wb_dat_i[FWSC_B_ERR];
               if (wb_dat_i[FWSC_B_TRIG]) begin
                  if (s_r.key == 2'h2 && wb_dat_i[FWSC_B_WEN]) begin
                     s_nxt.trig = 1'b1; // Software can only set it
                     s_nxt.st = FWSC_SETUP;
                     s_nxt.setup = FWSC_SETUP_CYC;
                  end else begin
                     s_nxt.err = 1'b1; // Unlock missing or write enable clear
                  end
               end
            end
         end else if (wb_adr_i == FWSC_ADRH_ADR && s_r.st == FWSC_IDLE) begin
            s_nxt.ah = wb_dat_i[FWSC_AH_W-1:0];
            s_nxt.key = 2'h0;
         end else if (wb_adr_i == FWSC_ADRL_ADR && s_r.st == FWSC_IDLE) begin
            s_nxt.al = wb_dat_i[FWSC_AL_W-1:0];
            s_nxt.key = 2'h0;
         end else begin
            s_nxt.key = 2'h0;
         end
      end else if (acc && wb_we_i) begin
         s_nxt.key = 2'h0;
      end
      // Sequencer
      case (s_r.st)
         FWSC_IDLE: begin
            s_nxt.stall = 1'b0;
         end
         FWSC_SETUP: begin
            // Two cycles the core spends on the no-ops
            s_nxt.setup = s_r.setup - 2'h1;
            if (s_r.setup == 2'h1) begin
               s_nxt.cmd.start = 1'b1;
               s_nxt.cmd.erase = s_r.erase;
               s_nxt.cmd.latch = s_r.latch;
               if (s_r.latch) begin
                  s_nxt.st = FWSC_DONE;
               end else begin
                  s_nxt.stall = 1'b1;
                  s_nxt.st = FWSC_BUSY;
               end
            end
         end
         FWSC_BUSY: begin
            // Only execution halts; the block has no clock gating
            if (tmr_exp || array_done_i) begin
               s_nxt.st = FWSC_DONE;
            end
         end
         FWSC_DONE: begin
            s_nxt.stall = 1'b0;
            s_nxt.trig = 1'b0;
            s_nxt.st = FWSC_IDLE;
         end
         default: begin
            s_nxt.st = FWSC_IDLE;
         end
      endcase
   end
   // Register all state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '0;
         s_r.st <= FWSC_IDLE;
      end else if (ce_i) begin
         s_r <= s_nxt;
      end
   end
   // ------------------------------------------------------------
   // Timed write counter
   // ------------------------------------------------------------
   fwsc_timer #(
      .CNT_W(CNT_W)
   ) u_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .load_i(tmr_load),
      .count_i(CNT_W'(WRITE_CYC)),
      .expired_o(tmr_exp)
   );
   assign wb_ack_o = s_r.ack;
   assign wb_dat_o = s_r.dat;
   assign stall_o = s_r.stall;
   assign cmd_o = s_r.cmd;
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence trig_seq;
      ce_i && s_r.st == FWSC_IDLE && s_nxt.st == FWSC_SETUP;
   endsequence
   sequence setup2_seq;
      ce_i [*2];
   endsequence
   setup_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
      trig_seq ##1 setup2_seq |=> cmd_o.start)
      else $error("start not two cycles after trigger");
   stall_last_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(stall_o) |-> $past(s_r.st) == FWSC_SETUP && !s_r.latch)
      else $error("stall without final write");
   stall_busy_a: assert property (@(posedge clk_i) disable iff (rst_i)
      stall_o |-> s_r.st inside {FWSC_BUSY, FWSC_DONE})
      else $error("stall outside write");
   latch_nostall_a: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd_o.start && cmd_o.latch |-> !stall_o ##1 !stall_o)
      else $error("latch load stalled core");
   erase_pass_a: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd_o.start |-> cmd_o.erase == s_r.erase)
      else $error("erase select lost");
   addr_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd_o.start |-> cmd_o.addr == {s_r.ah, s_r.al})
      else $error("array address wrong");
   trig_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && s_r.st == FWSC_DONE |=> !s_r.trig && !stall_o)
      else $error("trigger not cleared");
   resume_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(stall_o) |-> s_r.st == FWSC_IDLE && !s_r.trig)
      else $error("resume not at idle");
   unlock_a: assert property (@(posedge clk_i) disable iff (rst_i)
      trig_seq |-> s_r.key == 2'h2)
      else $error("trigger without unlock");
endmodule
`default_nettype wire
